// ===== src/pif_flag_reg.sv
// Peripheral interrupt request flag register with enable and clear
// Notes on behaviour
// - Bit 7 holds timer1 gate pending flag
// - Bit 6 holds converter done pending flag
// - Bit 3 holds serial port pending flag
// - Bit 1 set on timer2 period match
// - Bit 0 set on timer1 overflow
// - Flags set regardless of any enable
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
module pif_flag_reg (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire pif_pkg::pif_events_t events_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  // Flag bits, enable register and unregistered next read data
  logic [7:0] flags;
  logic [7:0] enable;
  logic [7:0] next_rdata;

  // Register decode
  wire hit_flags = addr_i == pif_pkg::OFF_FLAGS;
  wire hit_enable = addr_i == pif_pkg::OFF_ENABLE;
  wire hit_clear = addr_i == pif_pkg::OFF_CLEAR;
  wire hit_status = addr_i == pif_pkg::OFF_STATUS;
  wire wr_flags = wr_i & hit_flags;
  wire wr_enable = wr_i & hit_enable;
  wire wr_clear = wr_i & hit_clear;

  // Source events placed at their bit positions; enables play no part
  logic [7:0] hw_set;
  assign hw_set = {events_i.timer1_gate,
                   events_i.converter_done,
                   2'b00,
                   events_i.serial_port,
                   1'b0,
                   events_i.timer2_match,
                   events_i.timer1_overflow};

  // Writing 0 to a flag clears it, writing 1 sets it; clear reg is write-one
  wire [7:0] sw_set = {8{wr_flags}} & wdata_i;
  wire [7:0] sw_clr = ({8{wr_flags}} & ~wdata_i) | ({8{wr_clear}} & wdata_i);

  // One cell per implemented bit, tie-off elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      if (pif_pkg::IMPL_MASK[gi]) begin : g_cell
        pif_flag_cell u_cell (
          .ref_clk_i(ref_clk_i),
          .sys_rst_i(sys_rst_i),
          .hw_set_i(hw_set[gi]),
          .sw_set_i(sw_set[gi]),
          .sw_clr_i(sw_clr[gi]),
          .flag_o(flags[gi])
        );
      end else begin : g_none
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // Enable register; absent bits never store
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      enable <= pif_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable <= wdata_i & pif_pkg::IMPL_MASK;
    end
  end

  // Read mux; clear register and unmapped offsets read zero
  assign next_rdata = !rd_i ? pif_pkg::RDATA_RESET :
                      (hit_flags | hit_status) ? flags :
                      hit_enable ? enable : pif_pkg::RDATA_RESET;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= pif_pkg::RDATA_RESET;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Level interrupt while any enabled flag is pending.
  // Software should clear old flags first, else an enable fires at once.
  assign irq_o = |(flags & enable);

  // Helper: previous-cycle copies for assertions
  logic [7:0] past_flags;
  logic [7:0] past_hw_set;
  logic past_valid;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      past_flags <= 8'h00;
      past_hw_set <= 8'h00;
      past_valid <= 1'b0;
    end else begin
      past_flags <= flags;
      past_hw_set <= hw_set;
      past_valid <= 1'b1;
    end
  end

  // Event followed by its flag one cycle later
  sequence s_gate_event;
    events_i.timer1_gate;
  endsequence
  sequence s_gate_flag;
    ##1 flags[pif_pkg::BIT_TIMER1_GATE];
  endsequence

  a_gate_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i) s_gate_event |-> s_gate_flag)
    else $error("timer1 gate event did not set bit 7");

  a_conv_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.converter_done |=> flags[pif_pkg::BIT_CONVERTER_DONE])
    else $error("converter event did not set bit 6");

  a_serial_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.serial_port && wr_clear |=> flags[pif_pkg::BIT_SERIAL_PORT])
    else $error("serial port event lost against clear");

  a_timer2_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.timer2_match && wr_flags |=> flags[pif_pkg::BIT_TIMER2_MATCH])
    else $error("timer2 match lost against flag write");

  a_ovf_read_back: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.timer1_overflow ##1 (rd_i && hit_flags && !wr_i) |=> rdata_o[0])
    else $error("timer1 overflow not seen on read");

  a_absent_bits_zero: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (flags & ~pif_pkg::IMPL_MASK) == 8'h00 && (rdata_o & ~pif_pkg::IMPL_MASK) == 8'h00)
    else $error("unimplemented bit reads one");

  a_set_ignores_enable: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    past_valid && enable == 8'h00 |-> (flags & past_hw_set) == past_hw_set)
    else $error("flag not set while enables are off");

  a_flag_sticks: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(flags[0]) ##0 (!wr_i [*3]) |=> flags[0])
    else $error("flag dropped without a clear");

  a_clear_works: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_clear && wdata_i[0] && !events_i.timer1_overflow |=> !flags[0])
    else $error("clear register did not clear bit 0");

  a_irq_level: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    past_valid && wr_enable && (wdata_i & past_flags & flags) != 8'h00 |=> irq_o)
    else $error("enabled pending flag gave no interrupt");

  a_read_one_cycle: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood without a strobe");

  // Serial port sets its flag the cycle after its event
  a_serial_sets_flag: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.serial_port |=> flags[pif_pkg::BIT_SERIAL_PORT])
    else $error("serial port event did not set bit 3");

  // Timer2 match as two steps: the event, then the pending flag
  sequence s_match_event;
    events_i.timer2_match;
  endsequence
  sequence s_match_flag;
    ##1 flags[pif_pkg::BIT_TIMER2_MATCH];
  endsequence

  a_match_sets_flag: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i) s_match_event |-> s_match_flag)
    else $error("timer2 match did not set bit 1");

  // Overflow flag rises on every overflow event
  a_ovf_sets_flag: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    events_i.timer1_overflow |=> flags[pif_pkg::BIT_TIMER1_OVERFLOW])
    else $error("timer1 overflow did not set bit 0");

  // Flag offset reads back what the flags held at the strobe
  a_flags_read_back: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_i && hit_flags |=> rdata_o == $past(flags))
    else $error("flag read returned wrong data");

  // Status offset mirrors the flags
  a_status_mirror: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_i && hit_status |=> rdata_o == $past(flags))
    else $error("status read returned wrong data");

  // Writing zero to a flag clears it unless its event arrives too
  a_zero_write_clears: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_flags && !wdata_i[1] && !events_i.timer2_match |=> !flags[pif_pkg::BIT_TIMER2_MATCH])
    else $error("zero write did not clear bit 1");

  // Writing one to an implemented flag sets it
  a_one_write_sets: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_flags && wdata_i[3] |=> flags[pif_pkg::BIT_SERIAL_PORT])
    else $error("one write did not set bit 3");

  // Without a write no flag may fall; stickiness is the whole point
  a_no_write_holds: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !wr_i |=> (flags & $past(flags)) == $past(flags))
    else $error("flag fell with no write");

  // Enable write keeps only implemented bits
  a_enable_write: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_enable |=> enable == ($past(wdata_i) & pif_pkg::IMPL_MASK))
    else $error("enable write stored wrong value");

  // Absent enable bits never hold a one
  a_absent_enable_zero: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (enable & ~pif_pkg::IMPL_MASK) == 8'h00)
    else $error("unimplemented enable bit is set");

  // Reset clears all state; no disable here since reset is the trigger
  a_reset_clears: assert property (
    @(posedge ref_clk_i)
    sys_rst_i |=> flags == 8'h00 && enable == 8'h00 && rdata_o == 8'h00 && !irq_o)
    else $error("state not cleared by reset");
endmodule : pif_flag_reg

// ===== src/pif_pkg.sv
// Constants and carrier types for the peripheral interrupt flag register
package pif_pkg;
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_ENABLE = 4'h1;
  localparam logic [3:0] OFF_CLEAR = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  // Flag bit positions
  localparam int BIT_TIMER1_GATE = 7;
  localparam int BIT_CONVERTER_DONE = 6;
  localparam int BIT_SERIAL_PORT = 3;
  localparam int BIT_TIMER2_MATCH = 1;
  localparam int BIT_TIMER1_OVERFLOW = 0;
  // Implemented bits; 5, 4 and 2 are absent
  localparam logic [7:0] IMPL_MASK = 8'hCB;
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // One-cycle source event pulses from the peripherals
  typedef struct packed {
    logic timer1_gate;
    logic converter_done;
    logic serial_port;
    logic timer2_match;
    logic timer1_overflow;
  } pif_events_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pif_req_t;
endpackage : pif_pkg

// ===== src/pif_flag_cell.sv
// One sticky interrupt flag with hardware set priority
`timescale 1ns/10ps
module pif_flag_cell (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic hw_set_i,
  input wire logic sw_set_i,
  input wire logic sw_clr_i,
  output logic flag_o
);
  // Next flag value; any set beats the clear
  logic next_flag;
  assign next_flag = hw_set_i | sw_set_i | (flag_o & ~sw_clr_i);

  // Flag storage, cleared on reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end
endmodule : pif_flag_cell

// ===== tb/tb_top.sv
// Self-checking bench for the peripheral interrupt flag register
`timescale 1ns/10ps
module tb_top;
  logic ref_clk_i = 1'b0; // 25 MHz core clock
  logic sys_rst_i = 1'b1;
  pif_pkg::pif_events_t events_i = '0; // Source pulses
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  logic [7:0] fl = 8'h00; // Bench copy of the flags
  logic [7:0] c; // Random clear mask
  logic rd_d1 = 1'b0; // Read seen one edge ago
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  pif_pkg::pif_events_t ev;

  always #20 ref_clk_i = ~ref_clk_i;

  pif_flag_reg u_pif_flag_reg (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .events_i(events_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    num_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Flag positions of each source
  function automatic logic [7:0] bits(input pif_pkg::pif_events_t e);
    return {e.timer1_gate, e.converter_done, 2'b00, e.serial_port, 1'b0,
      e.timer2_match, e.timer1_overflow};
  endfunction : bits

  // One cycle of stimulus, then an idle cycle so strobes never merge
  task automatic op(input pif_pkg::pif_events_t e, input logic w, input logic r,
    input logic [3:0] a, input logic [7:0] d);
    events_i <= e;
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    events_i <= '0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : op

  task automatic rd(input logic [3:0] a, input logic [7:0] expv);
    exp_q.push_back(expv);
    op('0, 1'b0, 1'b1, a, 8'h00);
  endtask : rd

  // Irq is a level; let the edge's updates land first
  task automatic irq_is(input logic expv);
    #1;
    check("irq", {7'h00, irq_o}, {7'h00, expv});
  endtask : irq_is

  // Output watcher: read data one cycle after the strobe, else zero
  always @(posedge ref_clk_i) begin
    rd_d1 <= rd_i;
    cycles <= cycles + 1;
    if (rd_d1) begin
      check("rdata", rdata_o, exp_q.pop_front());
    end else if (!sys_rst_i) begin
      check("rdata_idle", rdata_o, 8'h00);
    end
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h202D));
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(pif_pkg::OFF_FLAGS, 8'h00);
    rd(pif_pkg::OFF_ENABLE, 8'h00);
    rd(4'h9, 8'h00);
    // Each source alone with all enables off
    for (int i = 0; i < 5; i++) begin
      ev = pif_pkg::pif_events_t'(5'h01 << i);
      op(ev, 1'b0, 1'b0, 4'h0, 8'h00);
      rd(pif_pkg::OFF_FLAGS, bits(ev));
      irq_is(1'b0);
      op('0, 1'b1, 1'b0, pif_pkg::OFF_CLEAR, 8'hFF);
    end
    // Absent bits ignore writes; writing zero clears
    op('0, 1'b1, 1'b0, pif_pkg::OFF_FLAGS, 8'hFF);
    rd(pif_pkg::OFF_STATUS, 8'hCB);
    op('0, 1'b1, 1'b0, pif_pkg::OFF_FLAGS, 8'h00);
    rd(pif_pkg::OFF_FLAGS, 8'h00);
    // Enabled match raises irq; other pending bits do not
    op('0, 1'b1, 1'b0, pif_pkg::OFF_ENABLE, 8'h02);
    irq_is(1'b0);
    op(5'h02, 1'b0, 1'b0, 4'h0, 8'h00);
    irq_is(1'b1);
    op(5'h01, 1'b1, 1'b0, pif_pkg::OFF_CLEAR, 8'h02);
    irq_is(1'b0);
    rd(pif_pkg::OFF_FLAGS, 8'h01);
    // Hardware set beats clear in the same cycle
    op(5'h10, 1'b1, 1'b0, pif_pkg::OFF_CLEAR, 8'h80);
    op(5'h0A, 1'b1, 1'b0, pif_pkg::OFF_FLAGS, 8'h00);
    rd(pif_pkg::OFF_FLAGS, 8'h42);
    fl = 8'h42;
    // Random sources against random clears
    for (int i = 0; i < 40; i++) begin
      ev = pif_pkg::pif_events_t'(5'($urandom));
      c = 8'($urandom);
      op(ev, 1'b1, 1'b0, pif_pkg::OFF_CLEAR, c);
      fl = (fl & ~c) | bits(ev);
      rd(pif_pkg::OFF_FLAGS, fl);
    end
    // Read straight after an event, no idle cycle between
    events_i <= 5'h01;
    @(posedge ref_clk_i);
    events_i <= '0;
    rd_i <= 1'b1;
    addr_i <= pif_pkg::OFF_FLAGS;
    exp_q.push_back(fl | 8'h01);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
    // Enabling a flag already pending fires at once
    op('0, 1'b1, 1'b0, pif_pkg::OFF_ENABLE, 8'h01);
    irq_is(1'b1);
    // Reset in mid-run clears flags, enable and irq
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    irq_is(1'b0);
    rd(pif_pkg::OFF_FLAGS, 8'h00);
    rd(pif_pkg::OFF_ENABLE, 8'h00);
    repeat (4) @(posedge ref_clk_i);
    tally_and_finish();
  end
endmodule : tb_top
